/* host_model.sv */
// remote controller model: issues one decoded command or query at a time on the command port
// assumes the block registers its answer at the edge that takes the request, in time for the next falling edge
`timescale 1ns/100ps
`default_nettype none

module host_model
   import status_sets_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_rsp_valid,
   input  wire logic [STAT_W-1:0] i_rsp_data,
   output logic                   o_cmd_valid,
   output logic                   o_cmd_write,
   output var reg_sel_t           o_cmd_sel,
   output logic [STAT_W-1:0]      o_cmd_data,
   output logic                   o_cmd_bound,
   output logic                   o_cmd_bound_max
);
   initial begin
      o_cmd_valid     = 1'b0;
      o_cmd_write     = 1'b0;
      o_cmd_sel       = SEL_DEV_COND;
      o_cmd_data      = 15'h5555;
      o_cmd_bound     = 1'b0;
      o_cmd_bound_max = 1'b0;
   end

   // ---------------------------------------------------------------
   // one transfer: drive on a falling edge, answer seen at the next one
   // ---------------------------------------------------------------
   // several bits are set by sending one word that is the sum of their weights
   task automatic xfer(input logic wr, input reg_sel_t sel, input logic [STAT_W-1:0] val,
                       input logic bnd, input logic bmax, output logic got, output logic [STAT_W-1:0] rd);
      @(negedge i_mclk);
      {o_cmd_valid, o_cmd_write, o_cmd_sel, o_cmd_data} = {1'b1, wr, sel, val};
      {o_cmd_bound, o_cmd_bound_max} = {bnd, bmax};
      @(negedge i_mclk);
      got = i_rsp_valid;
      rd  = i_rsp_data;
      // released lines except the select show the inverse so a stale value cannot pass for a fresh one
      {o_cmd_valid, o_cmd_write, o_cmd_data} = {1'b0, ~wr, ~val};
      {o_cmd_bound, o_cmd_bound_max} = {~bnd, ~bmax};
   endtask : xfer
endmodule : host_model

`default_nettype wire

/* status_register_sets.sv */
// status register sets: device-state and standard-operation condition, event,
// enable and transition registers behind a decoded query/command port
// assumes the condition inputs and command port are driven on i_mclk
//
// Notes on behaviour
// - every status register holds bits 0 to 14 and bit n weighs two to the n.
// - a write sets exactly the bits whose weights make up the written sum.
// - a read returns the weight sum of the bits that are one in the addressed register.
// - every read value is a plain integer, here the unsigned binary sum in the low 15 bits.
// - a device-state condition read returns its present contents.
// - a device-state event read returns its contents and then clears the event register.
// - the device-state enable register takes 0 to 32767 and reads back what was stored.
// - the device-state falling filter takes 0 to 32767 or a bound keyword and reads back.
// - the device-state rising filter takes 0 to 32767 or a bound keyword and reads back.
// - a standard-operation condition read returns its present contents.
// - the standard-operation enable takes 0 to 32767 or a bound keyword and reads back.
// - an instrument preset leaves enable and transition registers of both sets alone.
// - a status preset clears enables and falling filters and sets rising filters in both sets.
`timescale 1ns/100ps
`default_nettype none

module status_register_sets
   import status_sets_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_rst_b,
   input  wire logic [STAT_W-1:0] i_dev_cond,
   input  wire logic [STAT_W-1:0] i_oper_cond,
   input  wire logic              i_cmd_valid,
   input  wire logic              i_cmd_write,
   input  wire reg_sel_t          i_cmd_sel,
   input  wire logic [STAT_W-1:0] i_cmd_data,
   input  wire logic              i_cmd_bound,
   input  wire logic              i_cmd_bound_max,
   input  wire logic              i_status_preset,
   input  wire logic              i_inst_preset,
   output logic                   o_rsp_valid,
   output logic [STAT_W-1:0]      o_rsp_data,
   output logic                   o_dev_summary,
   output logic                   o_oper_summary
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [STAT_W-1:0] dev_cond_reg,   dev_cond_next;
   logic [STAT_W-1:0] dev_event_reg,  dev_event_next;
   logic [STAT_W-1:0] dev_enable_reg, dev_enable_next;
   logic [STAT_W-1:0] dev_fall_reg,   dev_fall_next;
   logic [STAT_W-1:0] dev_rise_reg,   dev_rise_next;
   logic [STAT_W-1:0] oper_cond_reg,  oper_cond_next;
   logic [STAT_W-1:0] oper_event_reg, oper_event_next;
   logic [STAT_W-1:0] oper_enable_reg, oper_enable_next;
   logic [STAT_W-1:0] oper_fall_reg,  oper_fall_next;
   logic [STAT_W-1:0] oper_rise_reg,  oper_rise_next;
   logic              rsp_valid_reg,  rsp_valid_next;
   logic [STAT_W-1:0] rsp_data_reg,   rsp_data_next;
   logic              dev_sum_reg,    dev_sum_next;
   logic              oper_sum_reg,   oper_sum_next;

   logic [STAT_W-1:0] wr_value;
   logic [STAT_W-1:0] dev_hits;
   logic [STAT_W-1:0] oper_hits;
   logic              wr_en;
   logic              rd_en;

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      wr_en = i_cmd_valid & i_cmd_write;
      rd_en = i_cmd_valid & ~i_cmd_write;
      // a bound keyword replaces the number
      if (i_cmd_bound) begin
         wr_value = i_cmd_bound_max ? BOUND_MAX_VAL : BOUND_MIN_VAL;
      end else begin
         wr_value = i_cmd_data;
      end

      // condition registers follow the instrument every clock
      dev_cond_next  = i_dev_cond;
      oper_cond_next = i_oper_cond;

      // edge detection against the previous condition value
      dev_hits  = (i_dev_cond & ~dev_cond_reg & dev_rise_reg)
                | (~i_dev_cond & dev_cond_reg & dev_fall_reg);
      oper_hits = (i_oper_cond & ~oper_cond_reg & oper_rise_reg)
                | (~i_oper_cond & oper_cond_reg & oper_fall_reg);

      // a read clears the event register, but a new hit in that cycle survives
      dev_event_next = dev_event_reg;
      if (rd_en && i_cmd_sel == SEL_DEV_EVENT) begin
         dev_event_next = EVENT_RST_VAL;
      end
      dev_event_next  = dev_event_next | dev_hits;
      oper_event_next = oper_event_reg | oper_hits;

      // the instrument preset is deliberately not used here: it must not
      // disturb enable or transition registers
      dev_enable_next  = dev_enable_reg;
      dev_fall_next    = dev_fall_reg;
      dev_rise_next    = dev_rise_reg;
      oper_enable_next = oper_enable_reg;
      oper_fall_next   = oper_fall_reg;
      oper_rise_next   = oper_rise_reg;
      if (i_status_preset) begin
         dev_enable_next  = ENABLE_PRESET;
         dev_fall_next    = FALL_PRESET;
         dev_rise_next    = RISE_PRESET;
         oper_enable_next = ENABLE_PRESET;
         oper_fall_next   = FALL_PRESET;
         oper_rise_next   = RISE_PRESET;
      end
      // a write in the same cycle as a status preset is applied after it
      if (wr_en) begin
         case (i_cmd_sel)
            SEL_DEV_ENABLE:  dev_enable_next  = wr_value;
            SEL_DEV_FALL:    dev_fall_next    = wr_value;
            SEL_DEV_RISE:    dev_rise_next    = wr_value;
            SEL_OPER_ENABLE: oper_enable_next = wr_value;
            default: begin
            end
         endcase
      end

      // every command is answered one clock later; writes echo nothing
      rsp_valid_next = i_cmd_valid;
      rsp_data_next  = rsp_data_reg;
      if (rd_en) begin
         case (i_cmd_sel)
            SEL_DEV_COND:    rsp_data_next = dev_cond_reg;
            SEL_DEV_EVENT:   rsp_data_next = dev_event_reg;
            SEL_DEV_ENABLE:  rsp_data_next = dev_enable_reg;
            SEL_DEV_FALL:    rsp_data_next = dev_fall_reg;
            SEL_DEV_RISE:    rsp_data_next = dev_rise_reg;
            SEL_OPER_COND:   rsp_data_next = oper_cond_reg;
            SEL_OPER_ENABLE: rsp_data_next = oper_enable_reg;
            default:         rsp_data_next = BOUND_MIN_VAL;
         endcase
      end

      dev_sum_next  = |(dev_event_next & dev_enable_next);
      oper_sum_next = |(oper_event_next & oper_enable_next);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dev_cond_reg    <= COND_RST_VAL;
         dev_event_reg   <= EVENT_RST_VAL;
         dev_enable_reg  <= ENABLE_RST_VAL;
         dev_fall_reg    <= FALL_RST_VAL;
         dev_rise_reg    <= RISE_RST_VAL;
         oper_cond_reg   <= COND_RST_VAL;
         oper_event_reg  <= EVENT_RST_VAL;
         oper_enable_reg <= ENABLE_RST_VAL;
         oper_fall_reg   <= FALL_RST_VAL;
         oper_rise_reg   <= RISE_RST_VAL;
         rsp_valid_reg   <= 1'b0;
         rsp_data_reg    <= BOUND_MIN_VAL;
         dev_sum_reg     <= 1'b0;
         oper_sum_reg    <= 1'b0;
      end else begin
         dev_cond_reg    <= dev_cond_next;
         dev_event_reg   <= dev_event_next;
         dev_enable_reg  <= dev_enable_next;
         dev_fall_reg    <= dev_fall_next;
         dev_rise_reg    <= dev_rise_next;
         oper_cond_reg   <= oper_cond_next;
         oper_event_reg  <= oper_event_next;
         oper_enable_reg <= oper_enable_next;
         oper_fall_reg   <= oper_fall_next;
         oper_rise_reg   <= oper_rise_next;
         rsp_valid_reg   <= rsp_valid_next;
         rsp_data_reg    <= rsp_data_next;
         dev_sum_reg     <= dev_sum_next;
         oper_sum_reg    <= oper_sum_next;
      end
   end

   // the response is the unsigned weight sum; text formatting lives upstream
   assign o_rsp_valid    = rsp_valid_reg;
   assign o_rsp_data     = rsp_data_reg;
   assign o_dev_summary  = dev_sum_reg;
   assign o_oper_summary = oper_sum_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   cond_read_a: assert property (
      (i_cmd_valid && !i_cmd_write && i_cmd_sel == SEL_DEV_COND)
      |=> (o_rsp_valid && o_rsp_data == $past(dev_cond_reg)))
      else $error("condition read returned a wrong value");

   event_read_clear_a: assert property (
      (i_cmd_valid && !i_cmd_write && i_cmd_sel == SEL_DEV_EVENT && dev_hits == 15'h0000)
      |=> (o_rsp_data == $past(dev_event_reg) && dev_event_reg == 15'h0000))
      else $error("event read did not return and clear");

   // a host that leaves one idle cycle between requests puts write and read-back
   // two edges apart; the idle cycle must not carry a preset or another write
   enable_write_a: assert property (
      (i_cmd_valid && i_cmd_write && !i_cmd_bound && i_cmd_sel == SEL_DEV_ENABLE)
      ##1 (!i_status_preset && !(i_cmd_valid && i_cmd_write))
      ##1 (i_cmd_valid && !i_cmd_write && i_cmd_sel == SEL_DEV_ENABLE && !i_status_preset)
      |=> (o_rsp_data == $past(i_cmd_data, 3)))
      else $error("enable read back differs from written value");

   fall_bound_a: assert property (
      (i_cmd_valid && i_cmd_write && i_cmd_bound && i_cmd_sel == SEL_DEV_FALL)
      |=> (dev_fall_reg == ($past(i_cmd_bound_max) ? 15'h7fff : 15'h0000)))
      else $error("falling filter bound not stored");

   rise_bound_a: assert property (
      (i_cmd_valid && i_cmd_write && i_cmd_bound && i_cmd_sel == SEL_DEV_RISE)
      |=> (dev_rise_reg == ($past(i_cmd_bound_max) ? 15'h7fff : 15'h0000)))
      else $error("rising filter bound not stored");

   oper_enable_a: assert property (
      (i_cmd_valid && i_cmd_write && i_cmd_sel == SEL_OPER_ENABLE)
      |=> (oper_enable_reg == ($past(i_cmd_bound) ? ($past(i_cmd_bound_max) ? 15'h7fff : 15'h0000)
                                                  : $past(i_cmd_data))))
      else $error("operation enable not stored");

   inst_preset_keep_a: assert property (
      (i_inst_preset && !i_status_preset && !(i_cmd_valid && i_cmd_write))
      |=> ($stable(dev_enable_reg) && $stable(dev_fall_reg) && $stable(dev_rise_reg)
           && $stable(oper_enable_reg) && $stable(oper_fall_reg) && $stable(oper_rise_reg)))
      else $error("instrument preset disturbed a mask register");

   status_preset_a: assert property (
      (i_status_preset && !i_cmd_valid)
      |=> (dev_enable_reg == 15'h0000 && dev_fall_reg == 15'h0000 && dev_rise_reg == 15'h7fff
           && oper_enable_reg == 15'h0000 && oper_fall_reg == 15'h0000 && oper_rise_reg == 15'h7fff))
      else $error("status preset left a wrong value");

   rise_event_a: assert property (
      ((i_dev_cond[0] && !dev_cond_reg[0] && dev_rise_reg[0]) ##1 (dev_event_reg[0]))
      or (!(i_dev_cond[0] && !dev_cond_reg[0] && dev_rise_reg[0])))
      else $error("rising condition did not set its event bit");

   summary_a: assert property (
      o_dev_summary == |(dev_event_reg & dev_enable_reg)
      && o_oper_summary == |(oper_event_reg & oper_enable_reg))
      else $error("summary flag does not match event and enable");

   rsp_timing_a: assert property (
      i_cmd_valid |=> o_rsp_valid ##1 !$past(i_cmd_valid) |-> !o_rsp_valid)
      else $error("response valid timing wrong");

   rsp_idle_a: assert property (
      !i_cmd_valid |=> !o_rsp_valid)
      else $error("answer strobe without a request");

   write_keeps_data_a: assert property (
      (i_cmd_valid && i_cmd_write)
      |=> $stable(o_rsp_data))
      else $error("a write changed the read data");

   oper_cond_read_a: assert property (
      (i_cmd_valid && !i_cmd_write && i_cmd_sel == SEL_OPER_COND)
      |=> (o_rsp_valid && o_rsp_data == $past(oper_cond_reg)))
      else $error("operation condition read returned a wrong value");

   top_bit_a: assert property (
      (i_cmd_valid && i_cmd_write && !i_cmd_bound && i_cmd_sel == SEL_DEV_ENABLE && i_cmd_data[14])
      |=> dev_enable_reg[14])
      else $error("bit fourteen of the enable register was not stored");

   fall_event_a: assert property (
      (!i_dev_cond[1] && dev_cond_reg[1] && dev_fall_reg[1])
      |=> dev_event_reg[1])
      else $error("falling condition did not set its event bit");

   // guards the filters on bit 0: an unfiltered transition must not set event bit 0
   quiet_event_a: assert property (
      (!dev_event_reg[0] && !(i_dev_cond[0] && !dev_cond_reg[0] && dev_rise_reg[0])
       && !(!i_dev_cond[0] && dev_cond_reg[0] && dev_fall_reg[0]))
      |=> !dev_event_reg[0])
      else $error("event bit set without a filtered transition");

   refused_write_a: assert property (
      (i_cmd_valid && i_cmd_write && i_cmd_sel == SEL_DEV_EVENT && dev_hits == 15'h0000)
      |=> $stable(dev_event_reg))
      else $error("a write changed the event register");

   preset_write_wins_a: assert property (
      (i_status_preset && i_cmd_valid && i_cmd_write && !i_cmd_bound && i_cmd_sel == SEL_OPER_ENABLE)
      |=> (oper_enable_reg == $past(i_cmd_data) && dev_enable_reg == 15'h0000))
      else $error("write beside a status preset was lost");

endmodule : status_register_sets

`default_nettype wire

/* status_sets_pkg.sv */
// package for the status register sets: register selects, widths and reset values
// assumes one instrument clock and a command decoder that turns text into selects and values
package status_sets_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int unsigned STAT_W = 15;

   // ---------------------------------------------------------------
   // bound keyword values and reset values
   // ---------------------------------------------------------------
   localparam logic [STAT_W-1:0] BOUND_MAX_VAL    = 15'h7fff;
   localparam logic [STAT_W-1:0] BOUND_MIN_VAL    = 15'h0000;
   localparam logic [STAT_W-1:0] ENABLE_RST_VAL   = 15'h0000;
   localparam logic [STAT_W-1:0] RISE_RST_VAL     = 15'h7fff;
   localparam logic [STAT_W-1:0] FALL_RST_VAL     = 15'h0000;
   localparam logic [STAT_W-1:0] EVENT_RST_VAL    = 15'h0000;
   localparam logic [STAT_W-1:0] COND_RST_VAL     = 15'h0000;
   // status preset values
   localparam logic [STAT_W-1:0] ENABLE_PRESET    = 15'h0000;
   localparam logic [STAT_W-1:0] RISE_PRESET      = 15'h7fff;
   localparam logic [STAT_W-1:0] FALL_PRESET      = 15'h0000;

   // ---------------------------------------------------------------
   // register selects
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_DEV_COND,
      SEL_DEV_EVENT,
      SEL_DEV_ENABLE,
      SEL_DEV_FALL,
      SEL_DEV_RISE,
      SEL_OPER_COND,
      SEL_OPER_ENABLE
   } reg_sel_t;

endpackage : status_sets_pkg

/* testbench.sv */
// self-checking bench for the status register sets
// assumes host_model drives the command port; the bench drives conditions and presets
`timescale 1ns/100ps
`default_nettype none

module testbench
   import status_sets_pkg::*;
;
   logic              i_mclk, i_rst_b, i_status_preset, i_inst_preset;
   logic [STAT_W-1:0] i_dev_cond, i_oper_cond, rsp_data, cmd_data;
   logic              rsp_valid, cmd_valid, cmd_write, cmd_bound, cmd_bound_max, dev_sum, oper_sum;
   reg_sel_t          cmd_sel;
   int                fail_count, checks;
   logic [STAT_W-1:0] last_rd;

   status_register_sets u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_dev_cond(i_dev_cond),
      .i_oper_cond(i_oper_cond), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_sel(cmd_sel),
      .i_cmd_data(cmd_data), .i_cmd_bound(cmd_bound), .i_cmd_bound_max(cmd_bound_max),
      .i_status_preset(i_status_preset), .i_inst_preset(i_inst_preset), .o_rsp_valid(rsp_valid),
      .o_rsp_data(rsp_data), .o_dev_summary(dev_sum), .o_oper_summary(oper_sum));
   host_model u_host (.i_mclk(i_mclk), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
      .o_cmd_valid(cmd_valid), .o_cmd_write(cmd_write), .o_cmd_sel(cmd_sel), .o_cmd_data(cmd_data),
      .o_cmd_bound(cmd_bound), .o_cmd_bound_max(cmd_bound_max));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [STAT_W-1:0] seen, input logic [STAT_W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic xfer(input logic wr, input reg_sel_t sel, input logic [STAT_W-1:0] val,
                       input logic bnd, input logic bmax, input logic [STAT_W-1:0] exp);
      logic              got;
      logic [STAT_W-1:0] rd;
      u_host.xfer(wr, sel, val, bnd, bmax, got, rd);
      check({14'h0000, got}, 15'h0001);
      // a write is answered too, but must leave the last read value standing
      if (!wr) begin
         check(rd, exp);
         last_rd = exp;
      end else begin
         check(rd, last_rd);
      end
   endtask : xfer

   task automatic rd(input reg_sel_t sel, input logic [STAT_W-1:0] exp);
      xfer(1'b0, sel, 15'h0000, 1'b0, 1'b0, exp);
   endtask : rd

   task automatic wr(input reg_sel_t sel, input logic [STAT_W-1:0] val);
      xfer(1'b1, sel, val, 1'b0, 1'b0, 15'h0000);
   endtask : wr

   // conditions change on a falling edge and are sampled at the next rising one
   task automatic set_cond(input logic [STAT_W-1:0] dev, input logic [STAT_W-1:0] oper);
      @(negedge i_mclk);
      {i_dev_cond, i_oper_cond} = {dev, oper};
      repeat (2) @(negedge i_mclk);
   endtask : set_cond

   task automatic pulse_preset(input logic status);
      @(negedge i_mclk);
      {i_status_preset, i_inst_preset} = {status, ~status};
      @(negedge i_mclk);
      {i_status_preset, i_inst_preset} = 2'b00;
   endtask : pulse_preset

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {fail_count, checks} = '0;
      {i_rst_b, i_status_preset, i_inst_preset} = 3'b000;
      {i_dev_cond, i_oper_cond} = {15'h0000, 15'h0000};
      last_rd = 15'h0000;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst_b = 1'b1;
      rd(SEL_DEV_ENABLE, ENABLE_RST_VAL);
      rd(SEL_DEV_FALL, FALL_RST_VAL);
      rd(SEL_DEV_RISE, RISE_RST_VAL);
      rd(SEL_OPER_ENABLE, ENABLE_RST_VAL);
      rd(SEL_DEV_EVENT, EVENT_RST_VAL);
      // condition reads, and rising edges under the all-ones rising filters
      set_cond(15'h0123, 15'h0456);
      rd(SEL_DEV_COND, 15'h0123);
      rd(SEL_OPER_COND, 15'h0456);
      wr(SEL_DEV_COND, 15'h7fff);
      rd(SEL_DEV_COND, 15'h0123);
      rd(SEL_DEV_EVENT, 15'h0123);
      rd(SEL_DEV_EVENT, 15'h0000);
      // the event register is read-only: a write is answered and ignored
      wr(SEL_DEV_EVENT, 15'h7fff);
      rd(SEL_DEV_EVENT, 15'h0000);
      // weight sums and the top bit
      wr(SEL_DEV_ENABLE, 15'h7fff);
      rd(SEL_DEV_ENABLE, 15'h7fff);
      wr(SEL_OPER_ENABLE, 15'h4000);
      rd(SEL_OPER_ENABLE, 15'h4000);
      check({14'h0000, oper_sum}, 15'h0000);
      wr(SEL_OPER_ENABLE, 15'h0004);
      check({14'h0000, oper_sum}, 15'h0001);
      // bound keywords
      xfer(1'b1, SEL_DEV_FALL, 15'h0000, 1'b1, 1'b1, 15'h0000);
      rd(SEL_DEV_FALL, BOUND_MAX_VAL);
      xfer(1'b1, SEL_DEV_RISE, 15'h0000, 1'b1, 1'b0, 15'h0000);
      rd(SEL_DEV_RISE, BOUND_MIN_VAL);
      xfer(1'b1, SEL_OPER_ENABLE, 15'h0000, 1'b1, 1'b1, 15'h0000);
      rd(SEL_OPER_ENABLE, BOUND_MAX_VAL);
      // filtered transitions: only bit 0 rising and bit 1 falling count
      wr(SEL_DEV_RISE, 15'h0001);
      wr(SEL_DEV_FALL, 15'h0002);
      wr(SEL_DEV_ENABLE, 15'h0002);
      rd(SEL_DEV_ENABLE, 15'h0002);
      set_cond(15'h0002, 15'h0456);
      rd(SEL_DEV_EVENT, 15'h0000);
      check({14'h0000, dev_sum}, 15'h0000);
      set_cond(15'h0001, 15'h0456);
      check({14'h0000, dev_sum}, 15'h0001);
      rd(SEL_DEV_EVENT, 15'h0003);
      check({14'h0000, dev_sum}, 15'h0000);
      // instrument preset leaves enables and filters alone
      pulse_preset(1'b0);
      rd(SEL_DEV_ENABLE, 15'h0002);
      rd(SEL_DEV_FALL, 15'h0002);
      rd(SEL_DEV_RISE, 15'h0001);
      rd(SEL_OPER_ENABLE, BOUND_MAX_VAL);
      // status preset restores enables and filters of both sets
      pulse_preset(1'b1);
      rd(SEL_DEV_ENABLE, ENABLE_PRESET);
      rd(SEL_DEV_FALL, FALL_PRESET);
      rd(SEL_DEV_RISE, RISE_PRESET);
      rd(SEL_OPER_ENABLE, ENABLE_PRESET);
      check({14'h0000, oper_sum}, 15'h0000);
      // a write taken at the same edge as a status preset wins for its own register
      fork
         pulse_preset(1'b1);
         wr(SEL_OPER_ENABLE, 15'h0040);
      join
      rd(SEL_OPER_ENABLE, 15'h0040);
      rd(SEL_DEV_ENABLE, ENABLE_PRESET);
      check({14'h0000, oper_sum}, 15'h0001);
      give_verdict();
   end
endmodule : testbench

`default_nettype wire
